// File: core/pmwc_power_mode_wake_controller.sv
/*
 * Power mode and wake controller: system clock source and divider
 * select, halt entry into sleep or idle, wake-up decision, power-down
 * and timeout flags, watchdog counter, oscillator stabilise counters.
 * Assumes oscillator ticks and CPU strobes are synchronous single-cycle
 * pulses on ref_clk_i, which stands for the high speed clock.
 */
`timescale 1ns/1ps
module pmwc_power_mode_wake_controller
	import pmwc_pkg::*;
#(
	parameter logic [SST_W-1:0] INT_HI_RC_SST_CYC = 12'h100,
	parameter logic [SST_W-1:0] HXT_SST_CYC  = 12'h400,
	parameter logic [SST_W-1:0] LXT_SST_CYC  = 12'h800,
	parameter logic [WDT_W-1:0] WDT_TOP      = 16'h00FF
) (
	// Clock and reset
	input  wire logic        ref_clk_i,
	input  wire logic        srst_i,
	// APB slave
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	// CPU core
	input  wire logic        halt_i,
	input  wire logic        clr_wdt_i,
	input  wire logic [7:0]  int_req_i,
	input  wire logic [7:0]  int_en_i,
	input  wire logic        stack_full_i,
	output logic             cpu_run_o,
	output logic             resume_next_o,
	output logic             int_respond_o,
	output logic             pc_sp_reset_o,
	output logic             wdt_reset_o,
	// Port A and low speed ticks
	input  wire logic [7:0]  porta_i,
	input  wire logic        int_low_rc_tick_i,
	input  wire logic        lxt_tick_i,
	// Clock control
	output logic             sys_tick_o,
	output logic             periph_tick_o,
	output logic             int_hi_rc_run_o,
	output logic             hxt_run_o,
	output logic             lxt_run_o,
	output logic [2:0]       power_mode_o
);
	pmwc_state_t state_reg, state_next;
	pmwc_wake_t  wake_kind_reg;
	logic [7:0]       sys_clock_control_reg;
	logic [7:0]       osc_ctrl_reg;
	logic [7:0]       porta_wake_enable;
	logic             wdt_en_reg;
	logic             powered_down_flag;
	logic             wdt_timeout_flag;
	logic             act_sub_reg;
	logic [7:0]       pend_mask_reg;
	logic [7:0]       porta_prev_reg;
	logic [5:0]       div_cnt_reg;
	logic [WDT_W-1:0] wdt_cnt_reg;
	logic [2:0]       osc_on;
	logic [2:0]       osc_restart;
	logic [2:0]       osc_stable;
	logic [SST_W-1:0] sst_limit [3];
	logic [2:0] sys_clk_div_sel;
	logic       low_clk_src_sel;
	logic       hi_src_ext;
	logic       fast_osc_idle_keep;
	logic       slow_osc_idle_keep;
	logic       hi_need;
	logic       sub_need;
	logic       hi_stable;
	logic       sub_stable;
	logic       sub_tick;
	logic       hi_tick;
	logic [6:0] div_one;
	logic [5:0] div_mask;
	logic       wr_en;
	logic       halt_entry;
	logic       wdt_ovf;
	logic       pa_wake;
	logic [7:0] int_wake;
	logic       wake;
	logic       src_ready;
	logic [2:0] mode_now;

	assign sys_clk_div_sel    = sys_clock_control_reg[SCC_DIV_HI:SCC_DIV_LO];
	assign hi_src_ext         = sys_clock_control_reg[SCC_FHS];
	assign low_clk_src_sel    = sys_clock_control_reg[SCC_FSS];
	assign fast_osc_idle_keep = sys_clock_control_reg[SCC_FKEEP];
	assign slow_osc_idle_keep = sys_clock_control_reg[SCC_SKEEP];

	// APB: zero wait states, answer in the cycle after setup
	assign wr_en = psel_i & penable_i & pwrite_i & pready_o;

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			pready_o  <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o  <= 32'h0000_0000;
		end else begin
			pready_o  <= psel_i & ~penable_i;
			pslverr_o <= 1'b0;
			prdata_o  <= 32'h0000_0000;
			if (psel_i & ~penable_i) begin
				case (paddr_i)
					ADDR_SCC:  prdata_o[7:0] <= sys_clock_control_reg;
					ADDR_OSC:  prdata_o[7:0] <= {osc_stable[OSC_LXT], osc_ctrl_reg[OSC_LXT_EN],
						osc_stable[OSC_HXT], osc_ctrl_reg[OSC_HXT_EN],
						osc_ctrl_reg[OSC_FREQ_HI:OSC_FREQ_LO], osc_stable[OSC_INT_HI_RC],
						osc_ctrl_reg[OSC_INT_HI_RC_EN]};
					ADDR_STAT: begin
						prdata_o[STAT_PDF]                   <= powered_down_flag;
						prdata_o[STAT_TO]                    <= wdt_timeout_flag;
						prdata_o[STAT_MODE_HI:STAT_MODE_LO] <= power_mode_o;
						prdata_o[STAT_SUB]                   <= act_sub_reg;
					end
					ADDR_PORTA_WAKE_ENABLE: prdata_o[7:0] <= porta_wake_enable;
					ADDR_WDT:  prdata_o[WDT_EN_BIT] <= wdt_en_reg;
					default:   pslverr_o <= 1'b1;
				endcase
			end
		end
	end

	// Only software writes move the select field; mode changes follow it
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			sys_clock_control_reg <= SCC_RST;
			osc_ctrl_reg          <= OSC_RST;
			porta_wake_enable     <= PORTA_WAKE_ENABLE_RST;
			wdt_en_reg            <= WDT_EN_RST;
		end else if (wr_en) begin
			case (paddr_i)
				ADDR_SCC:  sys_clock_control_reg <= pwdata_i[7:0] & SCC_MASK;
				ADDR_OSC:  osc_ctrl_reg <= pwdata_i[7:0] & OSC_WMASK;
				ADDR_PORTA_WAKE_ENABLE: porta_wake_enable <= pwdata_i[7:0];
				ADDR_WDT:  wdt_en_reg <= pwdata_i[WDT_EN_BIT];
				default:   ;
			endcase
		end
	end

	// Frequency change or fresh enable drops the stable flag first
	always_comb begin
		osc_restart = 3'h0;
		if (wr_en && paddr_i == ADDR_OSC) begin
			osc_restart[OSC_INT_HI_RC] = (pwdata_i[OSC_INT_HI_RC_EN] & ~osc_ctrl_reg[OSC_INT_HI_RC_EN])
				| (pwdata_i[OSC_FREQ_HI:OSC_FREQ_LO]
				!= osc_ctrl_reg[OSC_FREQ_HI:OSC_FREQ_LO]);
			osc_restart[OSC_HXT] = pwdata_i[OSC_HXT_EN] & ~osc_ctrl_reg[OSC_HXT_EN];
			osc_restart[OSC_LXT] = pwdata_i[OSC_LXT_EN] & ~osc_ctrl_reg[OSC_LXT_EN];
		end
	end

	// High oscillator is off in slow mode and in halt unless kept
	always_comb begin
		if (state_reg == ST_HALT) begin
			hi_need  = fast_osc_idle_keep;
			sub_need = slow_osc_idle_keep;
		end else begin
			hi_need  = (sys_clk_div_sel != DIV_SUB) | ~act_sub_reg;
			sub_need = (sys_clk_div_sel == DIV_SUB) | act_sub_reg;
		end
		osc_on[OSC_INT_HI_RC] = osc_ctrl_reg[OSC_INT_HI_RC_EN] & ~hi_src_ext & hi_need;
		osc_on[OSC_HXT]  = osc_ctrl_reg[OSC_HXT_EN] & hi_src_ext & hi_need;
		osc_on[OSC_LXT]  = osc_ctrl_reg[OSC_LXT_EN] & low_clk_src_sel & sub_need;
	end

	assign sst_limit[OSC_INT_HI_RC] = INT_HI_RC_SST_CYC;
	assign sst_limit[OSC_HXT]  = HXT_SST_CYC;
	assign sst_limit[OSC_LXT]  = LXT_SST_CYC;

	// One stabilise counter per oscillator, restarted whenever it stops
	for (genvar i = 0; i < 3; i++) begin : g_sst
		logic [SST_W-1:0] cnt_reg;
		always_ff @(posedge ref_clk_i) begin
			if (srst_i || !osc_on[i] || osc_restart[i]) begin
				cnt_reg <= '0;
			end else if (cnt_reg != sst_limit[i]) begin
				cnt_reg <= SST_W'(cnt_reg + 1'b1);
			end
		end
		assign osc_stable[i] = (cnt_reg == sst_limit[i]);
	end

	// The internal low RC is taken as always stable; it also feeds the watchdog
	assign hi_stable  = hi_src_ext ? osc_stable[OSC_HXT] : osc_stable[OSC_INT_HI_RC];
	assign sub_stable = low_clk_src_sel ? osc_stable[OSC_LXT] : 1'b1;
	assign sub_tick   = low_clk_src_sel ? (lxt_tick_i & osc_stable[OSC_LXT]) : int_low_rc_tick_i;

	// Divider on the high clock: tick when the low div bits are all zero
	assign div_one  = 7'h01 << sys_clk_div_sel;
	assign div_mask = 6'(div_one[5:0] - 6'h01);
	assign hi_tick  = hi_stable && ((div_cnt_reg & div_mask) == 6'h00);

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			div_cnt_reg <= 6'h00;
		end else begin
			div_cnt_reg <= 6'(div_cnt_reg + 6'h01);
		end
	end

	// Source changes over only once the new source is stable, so no runt cycle
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			act_sub_reg <= 1'b0;
		end else if (state_reg == ST_RUN) begin
			if (sys_clk_div_sel == DIV_SUB && sub_stable) begin
				act_sub_reg <= 1'b1;
			end else if (sys_clk_div_sel != DIV_SUB && hi_stable) begin
				act_sub_reg <= 1'b0;
			end
		end
	end

	// Wake sources
	assign halt_entry = (state_reg == ST_RUN) & halt_i;
	assign wdt_ovf    = wdt_en_reg & int_low_rc_tick_i & (wdt_cnt_reg == WDT_TOP);
	assign pa_wake    = |(porta_prev_reg & ~porta_i & porta_wake_enable);
	assign int_wake   = int_req_i & ~pend_mask_reg;
	assign wake       = pa_wake | (|int_wake) | wdt_ovf;
	assign src_ready  = act_sub_reg ? sub_stable : hi_stable;

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			porta_prev_reg <= 8'h00;
			pend_mask_reg  <= 8'h00;
		end else begin
			porta_prev_reg <= porta_i;
			if (halt_entry) begin
				pend_mask_reg <= int_req_i;
			end
		end
	end

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_BOOT: if (src_ready) state_next = ST_RUN;
			ST_RUN:  if (halt_i) state_next = ST_HALT;
			ST_HALT: if (wake) state_next = ST_WAKE;
			ST_WAKE: if (src_ready) state_next = ST_RUN;
			default: state_next = ST_BOOT;
		endcase
	end

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			state_reg <= ST_BOOT;
		end else begin
			state_reg <= state_next;
		end
	end

	// Watchdog overflow wins over other sources: it must reset PC and SP
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			wake_kind_reg <= WK_NEXT;
		end else if (state_reg == ST_HALT && wake) begin
			if (wdt_ovf) begin
				wake_kind_reg <= WK_WDT;
			end else if (|(int_wake & int_en_i) && !stack_full_i) begin
				wake_kind_reg <= WK_INT;
			end else begin
				wake_kind_reg <= WK_NEXT;
			end
		end
	end

	// Watchdog counter on the low RC tick; cleared by halt or clear request
	always_ff @(posedge ref_clk_i) begin
		if (srst_i || halt_entry || clr_wdt_i || wdt_ovf) begin
			wdt_cnt_reg <= '0;
		end else if (wdt_en_reg && int_low_rc_tick_i) begin
			wdt_cnt_reg <= WDT_W'(wdt_cnt_reg + 1'b1);
		end
	end

	// Set wins over clear on both flags
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			powered_down_flag <= 1'b0;
			wdt_timeout_flag  <= 1'b0;
		end else begin
			if (halt_entry) begin
				powered_down_flag <= 1'b1;
			end else if (clr_wdt_i) begin
				powered_down_flag <= 1'b0;
			end
			if (wdt_ovf) begin
				wdt_timeout_flag <= 1'b1;
			end else if (halt_entry || clr_wdt_i) begin
				wdt_timeout_flag <= 1'b0;
			end
		end
	end

	// Taken from the next state so the mode shows in the cycle cpu_run_o drops
	always_comb begin
		if (state_next == ST_HALT) begin
			case ({fast_osc_idle_keep, slow_osc_idle_keep})
				2'b00:   mode_now = MODE_SLEEP;
				2'b01:   mode_now = MODE_IDLE_SUB_ONLY;
				2'b11:   mode_now = MODE_IDLE_BOTH_CLOCKS;
				default: mode_now = MODE_IDLE_FAST_ONLY;
			endcase
		end else begin
			mode_now = act_sub_reg ? MODE_SLOW : MODE_FAST;
		end
	end

	// Registered outputs
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			cpu_run_o     <= 1'b0;
			resume_next_o <= 1'b0;
			int_respond_o <= 1'b0;
			pc_sp_reset_o <= 1'b0;
			wdt_reset_o   <= 1'b0;
			sys_tick_o    <= 1'b0;
			periph_tick_o <= 1'b0;
			int_hi_rc_run_o    <= 1'b0;
			hxt_run_o     <= 1'b0;
			lxt_run_o     <= 1'b0;
			power_mode_o  <= MODE_FAST;
		end else begin
			cpu_run_o     <= (state_next == ST_RUN) & ~halt_entry;
			resume_next_o <= (state_reg == ST_WAKE) & src_ready
				& (wake_kind_reg == WK_NEXT);
			int_respond_o <= (state_reg == ST_WAKE) & src_ready
				& (wake_kind_reg == WK_INT);
			pc_sp_reset_o <= (state_reg == ST_WAKE) & src_ready
				& (wake_kind_reg == WK_WDT);
			wdt_reset_o   <= wdt_ovf & (state_reg != ST_HALT);
			sys_tick_o    <= (state_reg == ST_RUN) & ~halt_i
				& (act_sub_reg ? sub_tick : hi_tick);
			periph_tick_o <= act_sub_reg ? (sub_tick & sub_need)
				: (hi_tick & hi_need);
			int_hi_rc_run_o    <= osc_on[OSC_INT_HI_RC];
			hxt_run_o     <= osc_on[OSC_HXT];
			lxt_run_o     <= osc_on[OSC_LXT];
			power_mode_o  <= mode_now;
		end
	end
endmodule : pmwc_power_mode_wake_controller

// File: core/pmwc_pkg.sv
/*
 * Constants, register map and types of the power mode wake controller.
 * Assumes a 32-bit APB master and a CPU core that pulses halt and
 * clear-watchdog requests synchronous to ref_clk_i.
 */
// Overview of operation
// - Clock select field or halt alone change mode
// - Select code 111 runs system on sub clock
// - Sub clock from chosen low oscillator, stable first
// - Codes 000-110 divide high clock by 1-64
// - Back to fast waits for high oscillator stable
// - Halt with both keep bits low: sleep
// - Halted core stops; all state is kept
// - Halt sets powered-down, clears timeout flag
// - Halt clears watchdog; it counts if enabled
// - Keep bits 0,1: sub clock only idle
// - Keep bits 1,1: both clocks keep running
// - Keep bits 1,0: high clock only idle
// - Wake on port edge, interrupt, watchdog overflow
// - Powered-down cleared only by reset, clear-watchdog
// - Watchdog wake sets timeout, resets PC/SP only
// - Per-pin port wake enable; resume after halt
// - Disabled or stack-full interrupt: resume after halt
// - Enabled interrupt, stack free: normal response
// - Request pending at halt cannot wake
// - First instruction waits for high oscillator stable
// - Each crystal has its own stabilise counter
// - Peripherals follow system clock source change
// - Select field bits 7-5, reset 000
// - Fast keep bit 1, slow keep bit 0
// - Internal RC enable/frequency change restarts stable flag
package pmwc_pkg;
	localparam logic [7:0] ADDR_SCC  = 8'h00;
	localparam logic [7:0] ADDR_OSC  = 8'h04;
	localparam logic [7:0] ADDR_STAT = 8'h08;
	localparam logic [7:0] ADDR_PORTA_WAKE_ENABLE = 8'h0C;
	localparam logic [7:0] ADDR_WDT  = 8'h10;
	localparam int SCC_DIV_HI = 7;
	localparam int SCC_DIV_LO = 5;
	localparam int SCC_FHS    = 3;
	localparam int SCC_FSS    = 2;
	localparam int SCC_FKEEP  = 1;
	localparam int SCC_SKEEP  = 0;
	localparam logic [7:0] SCC_RST  = 8'h00;
	localparam logic [7:0] SCC_MASK = 8'hEF;
	localparam logic [2:0] DIV_SUB  = 3'h7;
	localparam int OSC_INT_HI_RC_EN  = 0;
	localparam int OSC_INT_HI_RC_STB = 1;
	localparam int OSC_FREQ_LO  = 2;
	localparam int OSC_FREQ_HI  = 3;
	localparam int OSC_HXT_EN   = 4;
	localparam int OSC_HXT_STB  = 5;
	localparam int OSC_LXT_EN   = 6;
	localparam int OSC_LXT_STB  = 7;
	localparam logic [7:0] OSC_RST  = 8'h01;
	localparam logic [7:0] OSC_WMASK = 8'h5D;
	localparam int STAT_PDF     = 0;
	localparam int STAT_TO      = 1;
	localparam int STAT_MODE_LO = 2;
	localparam int STAT_MODE_HI = 4;
	localparam int STAT_SUB     = 5;
	localparam logic [7:0] PORTA_WAKE_ENABLE_RST = 8'h00;
	localparam int WDT_EN_BIT = 0;
	localparam logic WDT_EN_RST = 1'b1;
	localparam logic [2:0] MODE_FAST  = 3'h0;
	localparam logic [2:0] MODE_SLOW  = 3'h1;
	localparam logic [2:0] MODE_SLEEP = 3'h2;
	localparam logic [2:0] MODE_IDLE_SUB_ONLY = 3'h3;
	localparam logic [2:0] MODE_IDLE_BOTH_CLOCKS = 3'h4;
	localparam logic [2:0] MODE_IDLE_FAST_ONLY = 3'h5;
	localparam int OSC_INT_HI_RC = 0;
	localparam int OSC_HXT  = 1;
	localparam int OSC_LXT  = 2;
	localparam int SST_W    = 12;
	localparam int WDT_W    = 16;
	typedef enum logic [1:0] {WK_NEXT, WK_INT, WK_WDT} pmwc_wake_t;
	typedef enum {ST_BOOT, ST_RUN, ST_HALT, ST_WAKE} pmwc_state_t;
endpackage : pmwc_pkg

// File: dv/pmwc_checker.sv
/* Port assertions for the power mode wake controller.
   Bound into every controller instance; sees its ports only. */
`timescale 1ns/1ps
module pmwc_checker
	import pmwc_pkg::*;
(
	// Clock, reset and APB
	input wire logic        ref_clk_i,
	input wire logic        srst_i,
	input wire logic        psel_i,
	input wire logic        penable_i,
	input wire logic        pwrite_i,
	input wire logic [7:0]  paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic        pready_o,
	input wire logic        pslverr_o,
	// Core side
	input wire logic        halt_i,
	input wire logic        cpu_run_o,
	input wire logic        resume_next_o,
	input wire logic        int_respond_o,
	input wire logic        pc_sp_reset_o,
	input wire logic [2:0]  power_mode_o
);
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (srst_i);
	logic [1:0] keep_reg;
	logic [2:0] halt_mode;
	logic       scc_wr;
	// Shadow of the keep bits, taken from completed writes only
	assign scc_wr = psel_i && penable_i && pready_o && pwrite_i && paddr_i == ADDR_SCC;
	always_ff @(posedge ref_clk_i) begin
		if (srst_i)
			keep_reg <= 2'h0;
		else if (scc_wr)
			keep_reg <= pwdata_i[1:0];
	end
	assign halt_mode = keep_reg == 2'h0 ? MODE_SLEEP : keep_reg == 2'h1 ? MODE_IDLE_SUB_ONLY :
		keep_reg == 2'h3 ? MODE_IDLE_BOTH_CLOCKS : MODE_IDLE_FAST_ONLY;
	sequence s_setup; psel_i && !penable_i; endsequence
	sequence s_halt; halt_i && cpu_run_o; endsequence
	sequence s_wake; resume_next_o || int_respond_o || pc_sp_reset_o; endsequence
	a_ready_next: assert property (s_setup |=> pready_o)
		else $error("no ready after setup");
	a_ready_access: assert property (pready_o |-> psel_i && penable_i)
		else $error("ready outside access");
	a_err_ready: assert property (pslverr_o |-> pready_o)
		else $error("error without ready");
	a_halt_stop: assert property (s_halt |=> !cpu_run_o)
		else $error("core runs after halt");
	a_halt_mode: assert property (s_halt |=> power_mode_o == halt_mode)
		else $error("wrong halt mode");
	a_wake_one: assert property ($onehot0({resume_next_o, int_respond_o, pc_sp_reset_o}))
		else $error("two wake kinds");
	a_wake_run: assert property (s_wake |-> cpu_run_o)
		else $error("wake without run");
	a_resp_pulse: assert property (int_respond_o |=> !int_respond_o)
		else $error("long response pulse");
	a_slow_sel: assert property (scc_wr && pwdata_i[7:5] == DIV_SUB && cpu_run_o
		|-> ##[1:40] power_mode_o == MODE_SLOW)
		else $error("no slow mode");
endmodule : pmwc_checker
bind pmwc_power_mode_wake_controller pmwc_checker u_chk (.ref_clk_i(ref_clk_i),
	.srst_i(srst_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
	.paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o), .pslverr_o(pslverr_o),
	.halt_i(halt_i), .cpu_run_o(cpu_run_o), .resume_next_o(resume_next_o),
	.int_respond_o(int_respond_o), .pc_sp_reset_o(pc_sp_reset_o),
	.power_mode_o(power_mode_o));

// File: dv/pmwc_cpu_model.sv
/* Core stand-in: turns bench commands into halt and clear strobes,
   records how the last halt ended. Assumes one clock, sync reset. */
`timescale 1ns/1ps
module pmwc_cpu_model
	import pmwc_pkg::*;
(
	// Clock, reset, commands
	input  wire logic       ref_clk_i,
	input  wire logic       srst_i,
	input  wire logic       halt_cmd_i,
	input  wire logic       clr_cmd_i,
	// Controller side
	input  wire logic       cpu_run_i,
	input  wire logic       resume_next_i,
	input  wire logic       int_respond_i,
	input  wire logic       pc_sp_reset_i,
	output logic            halt_o,
	output logic            clr_wdt_o,
	output logic [1:0]      wake_kind_o
);
	logic armed_reg;
	// A stopped core fetches nothing, so one halt until halt_cmd_i drops again
	always_ff @(posedge ref_clk_i) begin
		halt_o <= 1'b0;
		clr_wdt_o <= clr_cmd_i && !srst_i;
		if (srst_i || !halt_cmd_i)
			armed_reg <= 1'b0;
		else if (cpu_run_i && !armed_reg) begin
			halt_o <= 1'b1;
			armed_reg <= 1'b1;
		end
	end
	// Cleared at halt so a missing wake pulse cannot pass as the old one
	always_ff @(posedge ref_clk_i) begin
		if (srst_i || halt_o)
			wake_kind_o <= 2'h0;
		else if (resume_next_i)
			wake_kind_o <= 2'h1;
		else if (int_respond_i)
			wake_kind_o <= 2'h2;
		else if (pc_sp_reset_i)
			wake_kind_o <= 2'h3;
	end
endmodule : pmwc_cpu_model

// File: dv/tb_top.sv
/* Self-checking bench for the power mode wake controller.
   Drives APB and the core model; short stabilise and watchdog counts. */
`timescale 1ns/1ps
module tb_top
	import pmwc_pkg::*;
;
	logic        ref_clk_i = 0, srst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0;
	logic        halt_cmd = 0, clr_cmd = 0, stack_full_i = 0, int_low_rc_tick_i = 0, int_low_rc_on = 0;
	logic [7:0]  paddr_i = 0, int_req_i = 0, int_en_i = 0, porta_i = 8'hFF;
	logic [31:0] pwdata_i = 0, prdata_o, rd;
	logic        pready_o, pslverr_o, halt_i, clr_wdt_i, cpu_run_o, sys_tick_o;
	logic        resume_next_o, int_respond_o, pc_sp_reset_o;
	logic [2:0]  power_mode_o;
	logic [1:0]  wake_kind;
	int          fails = 0, checks_done = 0, cyc = 0, n;
	always #5 ref_clk_i = ~ref_clk_i;
	// Low RC ticks every fourth cycle while enabled; hang guard
	always @(posedge ref_clk_i) begin
		cyc <= cyc + 1;
		int_low_rc_tick_i <= int_low_rc_on && cyc % 4 == 0;
		if (cyc == 20000) begin
			fails++;
			stop_test();
		end
	end
	pmwc_power_mode_wake_controller #(.INT_HI_RC_SST_CYC(12'h004), .HXT_SST_CYC(12'h004),
		.LXT_SST_CYC(12'h004), .WDT_TOP(16'h0008)) u_pmwc_power_mode_wake_controller (
		.ref_clk_i(ref_clk_i), .srst_i(srst_i), .psel_i(psel_i), .penable_i(penable_i),
		.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
		.pready_o(pready_o), .pslverr_o(pslverr_o), .halt_i(halt_i), .clr_wdt_i(clr_wdt_i),
		.int_req_i(int_req_i), .int_en_i(int_en_i), .stack_full_i(stack_full_i),
		.cpu_run_o(cpu_run_o), .resume_next_o(resume_next_o), .int_respond_o(int_respond_o),
		.pc_sp_reset_o(pc_sp_reset_o), .wdt_reset_o(), .porta_i(porta_i),
		.int_low_rc_tick_i(int_low_rc_tick_i), .lxt_tick_i(1'b0), .sys_tick_o(sys_tick_o),
		.periph_tick_o(), .int_hi_rc_run_o(), .hxt_run_o(), .lxt_run_o(),
		.power_mode_o(power_mode_o));
	pmwc_cpu_model u_pmwc_cpu_model (.ref_clk_i(ref_clk_i), .srst_i(srst_i),
		.halt_cmd_i(halt_cmd), .clr_cmd_i(clr_cmd), .cpu_run_i(cpu_run_o),
		.resume_next_i(resume_next_o), .int_respond_i(int_respond_o),
		.pc_sp_reset_i(pc_sp_reset_o), .halt_o(halt_i), .clr_wdt_o(clr_wdt_i),
		.wake_kind_o(wake_kind));
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk_i);
		psel_i <= 1'b1;
		pwrite_i <= wr;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge ref_clk_i);
		penable_i <= 1'b1;
		@(posedge ref_clk_i);
		while (pready_o !== 1'b1) @(posedge ref_clk_i);
		rd = wr ? {31'h0, pslverr_o} : prdata_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask : apb
	task automatic wait_run(input logic v);
		for (n = 0; n < 500 && cpu_run_o !== v; n++) @(posedge ref_clk_i);
		chk("cpu_run", cpu_run_o, v);
	endtask : wait_run
	task automatic halt_wake(input logic [1:0] keep, input logic [2:0] mode, input logic src,
		input logic [7:0] ie, input logic sf, input logic [1:0] kind);
		apb(1'b1, ADDR_SCC, {30'h0, keep});
		int_en_i <= ie;
		stack_full_i <= sf;
		halt_cmd <= 1'b1;
		wait_run(1'b0);
		chk("mode", power_mode_o, mode);
		apb(1'b0, ADDR_STAT, 32'h0);
		chk("status", rd & 32'h1F, {27'h0, mode, 2'h1});
		repeat (60) @(posedge ref_clk_i);
		chk("held", cpu_run_o, 1'b0);
		if (src)
			int_req_i <= 8'h01;
		else
			porta_i <= 8'hFE;
		wait_run(1'b1);
		@(posedge ref_clk_i);
		chk("wake kind", wake_kind, kind);
		int_req_i <= 8'h00;
		porta_i <= 8'hFF;
		halt_cmd <= 1'b0;
	endtask : halt_wake
	task automatic stop_test;
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : stop_test
	initial begin
		repeat (16) @(posedge ref_clk_i);
		srst_i <= 1'b0;
		apb(1'b0, ADDR_SCC, 32'h0);
		chk("control reset", rd, 32'h0);
		apb(1'b0, ADDR_WDT, 32'h0);
		chk("watchdog reset", rd, 32'h1);
		apb(1'b0, 8'h20, 32'h0);
		chk("unmapped", {pslverr_o, rd[30:0]}, 32'h8000_0000);
		wait_run(1'b1);
		apb(1'b1, ADDR_PORTA_WAKE_ENABLE, 32'h1);
		apb(1'b1, ADDR_WDT, 32'h0);
		apb(1'b0, ADDR_WDT, 32'h0);
		chk("watchdog off", rd, 32'h0);
		$display("reset and access done");
		halt_wake(2'h0, MODE_SLEEP, 1'b0, 8'h00, 1'b0, 2'h1);
		halt_wake(2'h1, MODE_IDLE_SUB_ONLY, 1'b1, 8'h00, 1'b0, 2'h1);
		halt_wake(2'h3, MODE_IDLE_BOTH_CLOCKS, 1'b1, 8'h01, 1'b0, 2'h2);
		halt_wake(2'h2, MODE_IDLE_FAST_ONLY, 1'b1, 8'h01, 1'b1, 2'h1);
		int_low_rc_on <= 1'b1;
		int_req_i <= 8'h02;
		halt_wake(2'h0, MODE_SLEEP, 1'b0, 8'h02, 1'b0, 2'h1);
		$display("halt and wake done");
		for (int d = 0; d < 7; d++) begin
			apb(1'b1, ADDR_SCC, 32'(d << 5));
			repeat (8) @(posedge ref_clk_i);
			n = 0;
			repeat (128) begin
				@(posedge ref_clk_i);
				if (sys_tick_o === 1'b1)
					n++;
			end
			chk("fast ticks", n, 128 >> d);
		end
		apb(1'b1, ADDR_SCC, 32'hE0);
		for (n = 0; n < 200 && power_mode_o !== MODE_SLOW; n++) @(posedge ref_clk_i);
		chk("slow", power_mode_o, MODE_SLOW);
		apb(1'b1, ADDR_SCC, 32'h0);
		for (n = 0; n < 200 && power_mode_o !== MODE_FAST; n++) @(posedge ref_clk_i);
		chk("fast", power_mode_o, MODE_FAST);
		$display("clock select done");
		apb(1'b1, ADDR_WDT, 32'h1);
		halt_cmd <= 1'b1;
		wait_run(1'b0);
		wait_run(1'b1);
		@(posedge ref_clk_i);
		int_low_rc_on <= 1'b0;
		halt_cmd <= 1'b0;
		chk("watchdog wake", wake_kind, 2'h3);
		apb(1'b0, ADDR_STAT, 32'h0);
		chk("flags", rd & 32'h3, 32'h3);
		clr_cmd <= 1'b1;
		@(posedge ref_clk_i);
		clr_cmd <= 1'b0;
		apb(1'b0, ADDR_STAT, 32'h0);
		chk("flags clear", rd & 32'h3, 32'h0);
		$display("watchdog done");
		stop_test();
	end
endmodule : tb_top
